/* File: tzf_consts.svh */
// register offsets, field positions and reset values of the trip flag block
`ifndef TZF_CONSTS_SVH
`define TZF_CONSTS_SVH

`define TZF_ADDR_W 3
`define TZF_DATA_W 16
`define TZF_FLAG_W 3

`define TZF_OFS_IRQ_ENABLE 3'h0
`define TZF_OFS_FLAG_STATUS 3'h1
`define TZF_OFS_FLAG_CLEAR 3'h2
`define TZF_OFS_FORCE 3'h3
`define TZF_OFS_EVT_STATUS 3'h4
`define TZF_OFS_EVT_ENABLE 3'h5
`define TZF_OFS_EVT_CLEAR 3'h6

`define TZF_BIT_OST 2
`define TZF_BIT_CBC 1
`define TZF_BIT_INT 0

`define TZF_EVT_OST 0
`define TZF_EVT_CBC 1
`define TZF_EVT_IRQ 2

`define TZF_RST_ENABLE 3'h0
`define TZF_RST_FLAGS 3'h0
`define TZF_RST_RDATA 16'h0000

`endif

/* File: tzf_pkg.sv */
// types shared by the trip flag and interrupt block
`include "tzf_consts.svh"
package tzf_pkg;

  typedef struct packed
  {
    logic wr;
    logic rd;
    logic [`TZF_ADDR_W-1:0] addr;
    logic [`TZF_DATA_W-1:0] wdata;
  } tzf_reg_bus_t;

  typedef struct packed
  {
    logic one_shot_trip;
    logic cbc;
    logic tb_zero;
  } tzf_trip_in_t;

  typedef logic [`TZF_FLAG_W-1:0] tzf_flags_t;

endpackage

/* File: tzf_sticky.sv */
// bank of sticky flags, set wins over clear
module tzf_sticky #(
  parameter int W = 3
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clr,
  output logic [W-1:0] o_q
);

  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      always_ff @(posedge i_ref_clk or negedge i_arst_n)
      begin
        if (!i_arst_n)
          o_q[g] <= 1'b0;
        else if (i_set[g])
          o_q[g] <= 1'b1;
        else if (i_clr[g])
          o_q[g] <= 1'b0;
      end

      set_wins_a: assert property (
        @(posedge i_ref_clk) disable iff (!i_arst_n)
        i_set[g] |=> o_q[g])
        else $error("sticky flag lost its set");
    end
  endgenerate

endmodule

/* File: tzf_cbc_latch.sv */
// cycle-by-cycle trip condition, released only at counter zero
module tzf_cbc_latch (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_set,
  input wire logic i_trip_lvl,
  input wire logic i_tb_zero,
  output logic o_active
);

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_active <= 1'b0;
    else if (i_set)
      o_active <= 1'b1;
    else if (i_tb_zero && !i_trip_lvl)
      o_active <= 1'b0;
  end

  cbc_release_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    $fell(o_active) |-> $past(i_tb_zero) && !$past(i_trip_lvl))
    else $error("cycle-by-cycle condition released off zero");

endmodule

/* File: tzf_trip_irq.sv */
// trip flag latching, interrupt gating and register port
//
// The strobed register port and the register addresses were decided locally.
`include "tzf_consts.svh"

// Overview of operation
// - one-shot enable bit 2 gates interrupt
// - cycle-by-cycle enable bit 1 gates interrupt
// - one-shot trip sets status bit 2
// - cycle-by-cycle flag bit 1 held until cleared
// - clear during active condition sets again
// - condition self-clears at zero without trip
// - condition released only at counter zero
// - interrupt flag bit 0 marks issued interrupt
// - set interrupt flag blocks further pulses
// - clearing interrupt flag with enabled flags pending repulses
// - clear register bits clear flags, read zero
// - force register bits 2 and 1 raise trip events
module tzf_trip_irq (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire tzf_pkg::tzf_reg_bus_t i_bus,
  output logic [`TZF_DATA_W-1:0] o_rdata,
  input wire tzf_pkg::tzf_trip_in_t i_trip,
  output logic o_trip_irq_out,
  output logic o_ost_tripped,
  output logic o_cbc_tripped,
  output logic o_irq
);
  import tzf_pkg::*;

  // ************************************************
  // address decode
  // ************************************************
  function automatic logic hit(
    input logic [`TZF_ADDR_W-1:0] a,
    input logic [`TZF_ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  logic wr_en;
  logic wr_clr;
  logic wr_frc;
  logic wr_evt_en;
  logic wr_evt_clr;

  assign wr_en = i_bus.wr && hit(i_bus.addr, `TZF_OFS_IRQ_ENABLE);
  assign wr_clr = i_bus.wr && hit(i_bus.addr, `TZF_OFS_FLAG_CLEAR);
  assign wr_frc = i_bus.wr && hit(i_bus.addr, `TZF_OFS_FORCE);
  assign wr_evt_en = i_bus.wr && hit(i_bus.addr, `TZF_OFS_EVT_ENABLE);
  assign wr_evt_clr = i_bus.wr && hit(i_bus.addr, `TZF_OFS_EVT_CLEAR);

  // ************************************************
  // interrupt enable register
  // ************************************************
  tzf_flags_t irq_en_q;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      irq_en_q <= `TZF_RST_ENABLE;
    else if (wr_en)
    begin
      irq_en_q[`TZF_BIT_OST] <= i_bus.wdata[`TZF_BIT_OST];
      irq_en_q[`TZF_BIT_CBC] <= i_bus.wdata[`TZF_BIT_CBC];
      irq_en_q[`TZF_BIT_INT] <= 1'b0;
    end
  end

  // ************************************************
  // trip events
  // ************************************************
  logic frc_ost;
  logic frc_cbc;
  logic ost_evt;
  logic cbc_evt;
  logic cbc_active;

  assign frc_ost = wr_frc && i_bus.wdata[`TZF_BIT_OST];
  assign frc_cbc = wr_frc && i_bus.wdata[`TZF_BIT_CBC];
  assign ost_evt = i_trip.one_shot_trip || frc_ost;
  assign cbc_evt = i_trip.cbc || frc_cbc;

  tzf_cbc_latch u_cbc_latch (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_set(cbc_evt),
    .i_trip_lvl(i_trip.cbc),
    .i_tb_zero(i_trip.tb_zero),
    .o_active(cbc_active)
  );

  // ************************************************
  // trip flag status register
  // ************************************************
  tzf_flags_t flag_q;
  tzf_flags_t flag_set;
  tzf_flags_t flag_clr;
  logic int_set;

  // only the clear register clears flags
  assign flag_clr = wr_clr ? i_bus.wdata[`TZF_FLAG_W-1:0]
                           : `TZF_RST_FLAGS;

  // interrupt only while the interrupt flag is low
  assign int_set = !flag_q[`TZF_BIT_INT]
    && ((flag_q[`TZF_BIT_OST] && irq_en_q[`TZF_BIT_OST])
    || (flag_q[`TZF_BIT_CBC] && irq_en_q[`TZF_BIT_CBC]));

  always_comb
  begin
    flag_set = `TZF_RST_FLAGS;
    flag_set[`TZF_BIT_OST] = ost_evt;
    flag_set[`TZF_BIT_CBC] = cbc_evt || cbc_active;
    flag_set[`TZF_BIT_INT] = int_set;
  end

  tzf_sticky #(
    .W(`TZF_FLAG_W)
  ) u_flags (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_set(flag_set),
    .i_clr(flag_clr),
    .o_q(flag_q)
  );

  assign o_ost_tripped = flag_q[`TZF_BIT_OST];
  assign o_cbc_tripped = cbc_active;

  // ************************************************
  // trip interrupt pulse
  // ************************************************
  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_trip_irq_out <= 1'b0;
    else
      o_trip_irq_out <= int_set;
  end

  // ************************************************
  // system event status, enable and clear
  // ************************************************
  tzf_flags_t evt_en_q;
  tzf_flags_t evt_q;
  tzf_flags_t evt_set;
  tzf_flags_t evt_clr;

  always_comb
  begin
    evt_set = `TZF_RST_FLAGS;
    evt_set[`TZF_EVT_OST] = ost_evt;
    evt_set[`TZF_EVT_CBC] = cbc_evt;
    evt_set[`TZF_EVT_IRQ] = int_set;
  end

  assign evt_clr = wr_evt_clr ? i_bus.wdata[`TZF_FLAG_W-1:0]
                              : `TZF_RST_FLAGS;

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      evt_en_q <= `TZF_RST_ENABLE;
    else if (wr_evt_en)
      evt_en_q <= i_bus.wdata[`TZF_FLAG_W-1:0];
  end

  tzf_sticky #(
    .W(`TZF_FLAG_W)
  ) u_events (
    .i_ref_clk(i_ref_clk),
    .i_arst_n(i_arst_n),
    .i_set(evt_set),
    .i_clr(evt_clr),
    .o_q(evt_q)
  );

  assign o_irq = |(evt_q & evt_en_q);

  // ************************************************
  // register read
  // ************************************************
  logic [`TZF_DATA_W-1:0] rd_mux;

  always_comb
  begin
    rd_mux = `TZF_RST_RDATA;
    unique case (i_bus.addr)
      `TZF_OFS_IRQ_ENABLE: rd_mux[`TZF_FLAG_W-1:0] = irq_en_q;
      `TZF_OFS_FLAG_STATUS: rd_mux[`TZF_FLAG_W-1:0] = flag_q;
      `TZF_OFS_EVT_STATUS: rd_mux[`TZF_FLAG_W-1:0] = evt_q;
      `TZF_OFS_EVT_ENABLE: rd_mux[`TZF_FLAG_W-1:0] = evt_en_q;
      default: rd_mux = `TZF_RST_RDATA;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_rdata <= `TZF_RST_RDATA;
    else if (i_bus.rd)
      o_rdata <= rd_mux;
    else
      o_rdata <= `TZF_RST_RDATA;
  end

  // ************************************************
  // checks
  // ************************************************
  ost_irq_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !flag_q[0] && flag_q[2] && irq_en_q[2] |=> o_trip_irq_out)
    else $error("one-shot flag did not raise interrupt");

  ost_masked_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !flag_q[0] && !irq_en_q[2] && !(flag_q[1] && irq_en_q[1])
    |=> !o_trip_irq_out)
    else $error("masked one-shot raised interrupt");

  cbc_irq_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !flag_q[0] && flag_q[1] && irq_en_q[1] |=> flag_q[0])
    else $error("cycle-by-cycle flag did not raise interrupt");

  ost_set_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_trip.one_shot_trip |=> flag_q[2])
    else $error("one-shot trip not latched");

  cbc_hold_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    flag_q[1] && !(wr_clr && i_bus.wdata[1]) |=> flag_q[1])
    else $error("cycle-by-cycle flag dropped without clear");

  cbc_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    cbc_active && wr_clr && i_bus.wdata[1] |=> flag_q[1])
    else $error("cycle-by-cycle flag not set again");

  int_block_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    flag_q[0] |=> !o_trip_irq_out)
    else $error("pulse while interrupt flag set");

  int_again_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    flag_q[0] && flag_q[2] && irq_en_q[2] && wr_clr
    && i_bus.wdata[0] && !i_bus.wdata[2]
    |-> ##2 o_trip_irq_out)
    else $error("no new pulse after interrupt flag clear");

  irq_pulse_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    o_trip_irq_out |-> $rose(flag_q[0]) ##1 !o_trip_irq_out)
    else $error("trip interrupt not a one-cycle pulse");

  clr_read_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    i_bus.rd && hit(i_bus.addr, `TZF_OFS_FLAG_CLEAR) |=> o_rdata == '0)
    else $error("clear register read nonzero");

  force_set_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    frc_cbc |=> flag_q[1] && cbc_active)
    else $error("force did not set cycle-by-cycle flag");

  cbc_masked_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !flag_q[0] && !irq_en_q[1] && !(flag_q[2] && irq_en_q[2])
    |=> !o_trip_irq_out)
    else $error("masked cycle-by-cycle raised interrupt");

  ost_quiet_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    !flag_q[2] && !ost_evt |=> !flag_q[2])
    else $error("one-shot flag set without trip");

  cbc_auto_clear_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    cbc_active && i_trip.tb_zero && !cbc_evt |=> !cbc_active)
    else $error("cycle-by-cycle condition kept at zero");

  cbc_stay_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    cbc_active && !i_trip.tb_zero |=> cbc_active)
    else $error("cycle-by-cycle condition left off zero");

  int_cause_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    $rose(flag_q[0]) |-> o_trip_irq_out)
    else $error("interrupt flag set without pulse");

  clr_ignore_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    flag_q[2] && wr_clr && !i_bus.wdata[2] |=> flag_q[2])
    else $error("zero written to clear dropped a flag");

  force_ost_a: assert property (
    @(posedge i_ref_clk) disable iff (!i_arst_n)
    frc_ost |=> flag_q[2])
    else $error("force did not set one-shot flag");

endmodule

/* File: tzf_trip_src.sv */
// trip detection and irq expander model
module tzf_trip_src (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_trip_irq_out,
  output tzf_pkg::tzf_trip_in_t o_trip,
  output logic [15:0] o_irq_count
);
  timeunit 1ns;
  timeprecision 1ps;
  import tzf_pkg::*;
  // ****************
  // trip stimulus
  // ****************
  initial o_trip = '0;
  task automatic ost_pulse();
    @(posedge i_ref_clk);
    o_trip.one_shot_trip <= 1'b1;
    @(posedge i_ref_clk);
    o_trip.one_shot_trip <= 1'b0;
  endtask
  task automatic cbc_set(input logic v);
    @(posedge i_ref_clk);
    o_trip.cbc <= v;
  endtask
  task automatic zero_pulse();
    @(posedge i_ref_clk);
    o_trip.tb_zero <= 1'b1;
    @(posedge i_ref_clk);
    o_trip.tb_zero <= 1'b0;
  endtask
  // ****************
  // expander side: count pulse cycles
  // ****************
  always @(posedge i_ref_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_irq_count <= 16'h0000;
    else if (i_trip_irq_out === 1'b1)
      o_irq_count <= o_irq_count + 16'h0001;
  end
endmodule

/* File: tzf_trip_irq_tb.sv */
// self-checking bench of the trip flag block
`include "tzf_consts.svh"
module tzf_trip_irq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tzf_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_arst_n = 1'b0;
  tzf_reg_bus_t bus = '0;
  tzf_trip_in_t trip;
  logic [15:0] rdata;
  logic irq_out;
  logic ost_t;
  logic cbc_t;
  logic irq;
  logic [15:0] irq_count;
  int errors = 0;
  int cmp_count = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  tzf_trip_irq tzf_trip_irq_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_bus(bus), .o_rdata(rdata), .i_trip(trip), .o_trip_irq_out(irq_out),
    .o_ost_tripped(ost_t), .o_cbc_tripped(cbc_t), .o_irq(irq));
  tzf_trip_src tzf_trip_src_i (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n),
    .i_trip_irq_out(irq_out), .o_trip(trip), .o_irq_count(irq_count));
  // ****************
  // bus tasks and compare
  // ****************
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_ref_clk);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= d;
    @(posedge i_ref_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [15:0] e, input string n);
    @(posedge i_ref_clk);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge i_ref_clk);
    bus.rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask
  task automatic settle();
    repeat (3) @(posedge i_ref_clk);
  endtask
  task automatic end_of_test();
    if (errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    errors++;
    end_of_test();
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    repeat (6) @(posedge i_ref_clk);
    i_arst_n <= 1'b1;
    rdchk(`TZF_OFS_IRQ_ENABLE, 16'h0000, "enable");
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "status");
    rdchk(`TZF_OFS_EVT_STATUS, 16'h0000, "evt_status");
    wr(`TZF_OFS_FLAG_STATUS, 16'h0007);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "status_ro");
    tzf_trip_src_i.ost_pulse();
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0004, "ost_masked");
    chk("ost_flag", {15'h0000, ost_t}, 16'h0001);
    chk("pulses", irq_count, 16'h0000);
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0004);
    wr(`TZF_OFS_IRQ_ENABLE, 16'h0006);
    rdchk(`TZF_OFS_IRQ_ENABLE, 16'h0006, "enable_rw");
    tzf_trip_src_i.ost_pulse();
    settle();
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0005, "ost_irq");
    chk("pulses", irq_count, 16'h0001);
    tzf_trip_src_i.ost_pulse();
    settle();
    chk("pulses", irq_count, 16'h0001);
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0001);
    settle();
    chk("pulses", irq_count, 16'h0002);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0005, "repulse");
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0000);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0005, "clr_zero");
    rdchk(`TZF_OFS_FLAG_CLEAR, 16'h0000, "clr_read");
    rdchk(`TZF_OFS_FORCE, 16'h0000, "frc_read");
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0007);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "clr_all");
    fork
      tzf_trip_src_i.ost_pulse();
      wr(`TZF_OFS_FLAG_CLEAR, 16'h0004);
    join
    settle();
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0005, "set_wins");
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0007);
    wr(`TZF_OFS_IRQ_ENABLE, 16'h0000);
    wr(`TZF_OFS_FORCE, 16'h0000);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "frc_zero");
    wr(`TZF_OFS_FORCE, 16'h0004);
    wr(`TZF_OFS_FORCE, 16'h0002);
    settle();
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0006, "frc_set");
    chk("pulses", irq_count, 16'h0003);
    tzf_trip_src_i.zero_pulse();
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0007);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "frc_rel");
    wr(`TZF_OFS_IRQ_ENABLE, 16'h0002);
    tzf_trip_src_i.cbc_set(1'b1);
    tzf_trip_src_i.zero_pulse();
    settle();
    chk("cbc_held", {15'h0000, cbc_t}, 16'h0001);
    tzf_trip_src_i.cbc_set(1'b0);
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0002);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0003, "cbc_again");
    chk("pulses", irq_count, 16'h0004);
    tzf_trip_src_i.zero_pulse();
    settle();
    chk("cbc_rel", {15'h0000, cbc_t}, 16'h0000);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0003, "cbc_sticky");
    wr(`TZF_OFS_FLAG_CLEAR, 16'h0003);
    rdchk(`TZF_OFS_FLAG_STATUS, 16'h0000, "cbc_clr");
    wr(`TZF_OFS_EVT_CLEAR, 16'h0007);
    wr(`TZF_OFS_EVT_ENABLE, 16'h0000);
    tzf_trip_src_i.ost_pulse();
    settle();
    rdchk(`TZF_OFS_EVT_STATUS, 16'h0001, "evt_ost");
    chk("irq_masked", {15'h0000, irq}, 16'h0000);
    wr(`TZF_OFS_EVT_ENABLE, 16'h0001);
    #1;
    chk("irq_on", {15'h0000, irq}, 16'h0001);
    wr(`TZF_OFS_EVT_CLEAR, 16'h0001);
    #1;
    chk("irq_off", {15'h0000, irq}, 16'h0000);
    rdchk(`TZF_OFS_EVT_STATUS, 16'h0000, "evt_clr");
    rdchk(3'h7, 16'h0000, "unmapped");
    end_of_test();
  end
endmodule
